/* cutoff_judge.sv */
`timescale 1ns/100ps
// Judges the three cutoff measurement levels against the loop limits.
module cutoff_judge
   import tube_seq_pkg::*;
(
   input wire logic [11:0] cut_r_mv,
   input wire logic [11:0] cut_g_mv,
   input wire logic [11:0] cut_b_mv,
   output logic fault_raw,
   output logic window_ok,
   output logic above_target
);
   logic [11:0] low_mv;

   // Smaller of two levels.
   function automatic logic [11:0] min2(input logic [11:0] a,
                                        input logic [11:0] b);
      min2 = (a < b) ? a : b;
   endfunction

   // Out of range test for one level.
   function automatic logic outside(input logic [11:0] v);
      outside = (v < CUT_LOW_MV) || (v > CUT_HIGH_MV);
   endfunction

   // Any one cathode out of range marks the loop as faulty.
   always_comb begin
      low_mv = min2(min2(cut_r_mv, cut_g_mv), cut_b_mv);
      fault_raw = outside(cut_r_mv) | outside(cut_g_mv) |
                  outside(cut_b_mv);
      window_ok = (low_mv >= CUT_TARGET_MV - CUT_WINDOW_MV) &&
                  (low_mv <= CUT_TARGET_MV + CUT_WINDOW_MV);
      above_target = low_mv > CUT_TARGET_MV;
   end
endmodule // cutoff_judge

/* defl_partner.sv */
`timescale 1ns/100ps
// Stand-in for the deflection stage and the mains supervisor.
module defl_partner #(
   parameter int FIELD = 100,
   parameter int DROP = 400
) (
   input wire logic hclk,
   input wire logic sag,
   output logic field_start = 1'b0,
   output logic meas_line = 1'b0,
   output logic mains_loss_discharge_pin = 1'b0,
   output logic supply_ok_pin = 1'b1
);
   int fcnt = 0;
   int scnt = 0;
   // One field pulse and a short measurement line in every field.
   always @(posedge hclk) begin
      fcnt <= (fcnt == FIELD - 1) ? 0 : fcnt + 1;
      field_start <= (fcnt == 0);
      meas_line <= (fcnt > 4 && fcnt < 9);
   end
   // A sag raises the pin at once; the supply only dies later.
   always @(posedge hclk) begin
      mains_loss_discharge_pin <= sag;
      scnt <= sag ? scnt + 1 : 0;
      supply_ok_pin <= !(sag && scnt >= DROP);
   end
endmodule // defl_partner

/* tube_seq.sv */
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
module tube_seq #(
   parameter int HOLD_CYC = tube_seq_pkg::BLANK_HOLD_CYC,
   parameter int STOP_CYC = tube_seq_pkg::SLOW_STOP_CYC,
   parameter int BEAM_CYC = tube_seq_pkg::FBEAM_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [11:0] cut_r_mv,
   input wire logic [11:0] cut_g_mv,
   input wire logic [11:0] cut_b_mv,
   input wire logic meas_line,
   input wire logic field_start,
   input wire logic [9:0] video_level,
   input wire logic signed [11:0] phase_err,
   input wire logic mains_loss_discharge_pin,
   input wire logic line_rate_sel_pin,
   input wire logic supply_ok_pin,
   output logic h_out_en,
   output logic [7:0] h_on_time,
   output logic rgb_blank,
   output logic cathode_calibration_loop,
   output logic loop_closed,
   output logic fixed_beam_force,
   output logic vert_overscan,
   output logic [1:0] soft_clip_offset,
   output logic soft_clip_on,
   output logic rg_gain_reduce,
   output logic double_rate,
   output logic signed [11:0] phase_corr
);
   import tube_seq_pkg::*;

   seq_state_t state_ff, nxt_state;
   logic [7:0] ctrl_ff;
   logic [4:0] phase_k_ff;
   logic [2:0] sync1_ff, sync2_ff;
   logic mains_s, rate_s, supply_s;
   logic fault_raw, window_raw, above_raw;
   logic black_loop_fault_ff, cutoff_window_ok_ff, cutoff_above_target_ff;
   logic por_flag_ff, blank_ff, beam_ff, h_on_ff;
   logic [31:0] hold_cnt_ff, stop_cnt_ff, step_cnt_ff;
   logic [7:0] on_time_ff;
   logic wr_ff;
   logic [7:0] addr_ff;
   logic [31:0] rd_data;
   logic standby_req, por_clr, switch_on;
   logic signed [16:0] corr_prod;
   logic [1:0] horizontal_release_bits;
   logic rgb_force_blank, blue_stretch_enable;
   logic fixed_beam_discharge_enable, overscan_on_off;

   assign horizontal_release_bits = ctrl_ff[REL_LSB +: 2];
   assign rgb_force_blank = ctrl_ff[FBLANK_BIT];
   assign blue_stretch_enable = ctrl_ff[BSTR_BIT];
   assign fixed_beam_discharge_enable = ctrl_ff[FBEAM_BIT];
   assign overscan_on_off = ctrl_ff[OSCAN_BIT];

   // Pins pass two flops; the first stage feeds only the second.
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               sync1_ff[gi] <= 1'b0;
               sync2_ff[gi] <= 1'b0;
            end else begin
               sync1_ff[gi] <= (gi == 0) ? mains_loss_discharge_pin :
                               (gi == 1) ? line_rate_sel_pin : supply_ok_pin;
               sync2_ff[gi] <= sync1_ff[gi];
            end
         end
      end
   endgenerate
   assign mains_s = sync2_ff[0];
   assign rate_s = sync2_ff[1];
   assign supply_s = sync2_ff[2];

   // Zero-wait slave: the address phase is captured, reads are staged early.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   always_comb begin
      rd_data = 32'h0000_0000;
      case (haddr[7:0])
         CTRL_OFS: rd_data = {24'h00_0000, ctrl_ff};
         STATUS_OFS: begin
            rd_data[FAULT_BIT] = black_loop_fault_ff;
            rd_data[WIN_BIT] = cutoff_window_ok_ff;
            rd_data[ABOVE_BIT] = cutoff_above_target_ff;
            rd_data[POR_BIT] = por_flag_ff;
            rd_data[DRATE_BIT] = rate_s;
            rd_data[STATE_LSB +: 6] = state_ff;
         end
         PHASE_K_OFS: rd_data = {27'h000_0000, phase_k_ff};
         default: rd_data = 32'h0000_0000;
      endcase
   end

   // Address phase bookkeeping and read data register.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ff <= 1'b0;
         addr_ff <= 8'h00;
         hrdata <= 32'h0000_0000;
      end else if (hready) begin
         wr_ff <= hsel && htrans[1] && hwrite;
         addr_ff <= haddr[7:0];
         if (hsel && htrans[1] && !hwrite) begin
            hrdata <= rd_data;
         end
      end
   end

   assign standby_req = wr_ff && addr_ff == CTRL_OFS && hwdata[STANDBY_BIT];
   assign por_clr = wr_ff && addr_ff == STATUS_OFS && hwdata[POR_BIT];

   // Control register; the slow stop state drops the release bits so the
   // tube stays off until software releases it again.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff <= CTRL_RST;
         phase_k_ff <= PHASE_K_RST;
      end else begin
         if (wr_ff && addr_ff == CTRL_OFS) begin
            ctrl_ff <= hwdata[7:0];
         end
         if (wr_ff && addr_ff == PHASE_K_OFS) begin
            phase_k_ff <= hwdata[4:0];
         end
         if (state_ff == ST_SOFT_STOP) begin
            ctrl_ff[REL_LSB +: 2] <= 2'b00;
         end
      end
   end

   // Sequencer next state; a supply drop overrides everything.
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_OFF: begin
            if (supply_s && horizontal_release_bits != 2'b00) begin
               nxt_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (mains_s) begin
               nxt_state = ST_MAINS_WAIT;
            end else if (standby_req) begin
               nxt_state = ST_STBY_WAIT;
            end
         end
         ST_STBY_WAIT: begin
            if (field_start) begin
               nxt_state = ST_SOFT_STOP;
            end
         end
         ST_SOFT_STOP: begin
            if (stop_cnt_ff >= 32'(STOP_CYC - 1)) begin
               nxt_state = ST_OFF;
            end
         end
         ST_MAINS_WAIT: begin
            if (field_start) begin
               nxt_state = ST_DISCHARGE;
            end
         end
         ST_DISCHARGE: nxt_state = ST_DISCHARGE;
         default: nxt_state = ST_OFF;
      endcase
      if (!supply_s) begin
         nxt_state = ST_OFF;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff <= ST_OFF;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign switch_on = state_ff == ST_OFF && nxt_state == ST_RUN;

   // Horizontal drive runs from release until soft stop ends or power fails.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         h_on_ff <= 1'b0;
      end else begin
         h_on_ff <= nxt_state != ST_OFF;
      end
   end

   // Slow stop counter and on-time ramp from nominal down to zero.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stop_cnt_ff <= 32'h0000_0000;
         step_cnt_ff <= 32'h0000_0000;
         on_time_ff <= 8'h00;
      end else if (state_ff != ST_SOFT_STOP) begin
         stop_cnt_ff <= 32'h0000_0000;
         step_cnt_ff <= 32'h0000_0000;
         on_time_ff <= (nxt_state == ST_OFF) ? 8'h00 : ON_TIME_NOM;
      end else begin
         stop_cnt_ff <= stop_cnt_ff + 32'h1;
         // A step period of STOP_CYC/256 lets all 255 steps fit the stop.
         if (step_cnt_ff + 32'h1 >= 32'(STOP_CYC / 256)) begin
            step_cnt_ff <= 32'h0000_0000;
            if (on_time_ff != 8'h00) begin
               on_time_ff <= on_time_ff - 8'h01;
            end
         end else begin
            step_cnt_ff <= step_cnt_ff + 32'h1;
         end
      end
   end

   // Fixed beam: first part of a soft stop, or the whole mains discharge.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         beam_ff <= 1'b0;
      end else begin
         beam_ff <= fixed_beam_discharge_enable && (
                    (nxt_state == ST_SOFT_STOP &&
                     (state_ff != ST_SOFT_STOP ||
                      stop_cnt_ff < 32'(BEAM_CYC - 1))) ||
                    nxt_state == ST_DISCHARGE);
      end
   end

   // Hold-off timer started when the horizontal output switches on.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hold_cnt_ff <= 32'h0000_0000;
      end else if (switch_on) begin
         hold_cnt_ff <= 32'(HOLD_CYC);
      end else if (hold_cnt_ff != 32'h0000_0000) begin
         hold_cnt_ff <= hold_cnt_ff - 32'h1;
      end
   end

   cutoff_judge u_judge (
      .cut_r_mv(cut_r_mv),
      .cut_g_mv(cut_g_mv),
      .cut_b_mv(cut_b_mv),
      .fault_raw(fault_raw),
      .window_ok(window_raw),
      .above_target(above_raw)
   );

   // Loop flags. The fault flag is forced on at switch-on because a warm
   // tube would otherwise give a bright flash before the hold-off ends.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         black_loop_fault_ff <= 1'b0;
         cutoff_window_ok_ff <= 1'b0;
         cutoff_above_target_ff <= 1'b0;
      end else begin
         cutoff_window_ok_ff <= window_raw;
         cutoff_above_target_ff <= above_raw;
         if (switch_on || (cathode_calibration_loop && fault_raw)) begin
            black_loop_fault_ff <= 1'b1;
         end else if (hold_cnt_ff == 32'h0000_0000) begin
            black_loop_fault_ff <= 1'b0;
         end
      end
   end

   // Power-on flag: a supply drop sets it, writing one clears it, set wins.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         por_flag_ff <= 1'b0;
      end else if (!supply_s) begin
         por_flag_ff <= 1'b1;
      end else if (por_clr) begin
         por_flag_ff <= 1'b0;
      end
   end

   // Start-up blanking ends on the falling edge of the fault flag.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         blank_ff <= 1'b1;
      end else if (switch_on || state_ff == ST_OFF) begin
         blank_ff <= 1'b1;
      end else if (black_loop_fault_ff && !fault_raw &&
                   hold_cnt_ff == 32'h0000_0000) begin
         blank_ff <= 1'b0;
      end
   end

   // Phase loop trim: error scaled by k in sixteenths.
   assign corr_prod = 17'(phase_err * $signed({1'b0, phase_k_ff}));
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_corr <= 12'sh000;
      end else begin
         phase_corr <= 12'(corr_prod >>> PHASE_K_SHIFT);
      end
   end

   // Output assembly.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rgb_blank <= 1'b1;
         vert_overscan <= 1'b0;
         rg_gain_reduce <= 1'b0;
         double_rate <= 1'b0;
         soft_clip_offset <= 2'h0;
         soft_clip_on <= 1'b0;
      end else begin
         rgb_blank <= blank_ff || rgb_force_blank;
         vert_overscan <= overscan_on_off && (state_ff == ST_SOFT_STOP ||
                          state_ff == ST_DISCHARGE);
         rg_gain_reduce <= blue_stretch_enable &&
                           video_level > BSTR_KNEE;
         double_rate <= rate_s;
         soft_clip_offset <= ctrl_ff[SCLIP_LSB +: 2];
         soft_clip_on <= ctrl_ff[SCLIP_LSB +: 2] != SCLIP_OFF;
      end
   end

   assign h_out_en = h_on_ff;
   assign h_on_time = on_time_ff;
   assign fixed_beam_force = beam_ff;
   assign cathode_calibration_loop = state_ff == ST_RUN;
   assign loop_closed = (cathode_calibration_loop && meas_line) ||
                        beam_ff;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   release_blank_a: assert property (
      switch_on |=> rgb_blank && black_loop_fault_ff)
      else $error("Release did not blank the outputs.");
   fault_hold_a: assert property (
      $fell(black_loop_fault_ff) |-> hold_cnt_ff == 32'h0000_0000)
      else $error("Fault flag cleared during the hold-off.");
   unblank_a: assert property (
      $fell(blank_ff) && !rgb_force_blank |=> !rgb_blank)
      else $error("Outputs stayed blanked after the fault fell.");
   force_blank_a: assert property (
      rgb_force_blank |=> rgb_blank)
      else $error("Force blank did not blank the outputs.");
   stop_sync_a: assert property (
      $rose(state_ff == ST_SOFT_STOP) |->
      $past(field_start) && $past(state_ff == ST_STBY_WAIT))
      else $error("Slow stop began off the field start.");
   beam_time_a: assert property (
      state_ff == ST_SOFT_STOP && stop_cnt_ff >= 32'(BEAM_CYC)
      |-> !fixed_beam_force)
      else $error("Fixed beam ran past its time.");
   mains_run_a: assert property (
      state_ff == ST_DISCHARGE |-> h_out_en && h_on_time == ON_TIME_NOM)
      else $error("Horizontal stopped during mains discharge.");
   por_stop_a: assert property (
      !supply_s |=> !h_out_en && por_flag_ff ##1 !fixed_beam_force)
      else $error("Supply drop did not stop the drive.");
   loop_open_a: assert property (
      loop_closed |-> meas_line || fixed_beam_force)
      else $error("Black loop closed outside its windows.");
   stop_end_a: assert property (
      $rose(state_ff == ST_SOFT_STOP) && supply_s |->
      ##1 (state_ff == ST_SOFT_STOP) [*4])
      else $error("Slow stop ended too early.");

   standby_c: cover property (state_ff == ST_SOFT_STOP && fixed_beam_force);
   mains_c: cover property (state_ff == ST_DISCHARGE && vert_overscan);
   unblank_c: cover property ($fell(rgb_blank));
endmodule // tube_seq

/* tube_seq_pkg.sv */
// What this block does
// - Release blanks RGB outputs and starts the cathode calibration loop.
// - Fault flag rises while any cutoff level is below 1.5 V or above 3.5 V.
// - RGB outputs unblank when the fault flag falls from one to zero.
// - Fault flag cannot clear until 0.5 s after horizontal switch-on.
// - Force-blank bit holds RGB at blanking whatever the fault flag says.
// - Window flag is one when lowest cutoff level is 2.5 V within 0.1 V.
// - Above-target flag is zero below 2.5 V and one above it.
// - Soft clip sits 0 to 10% above peak-white limit in 3 steps, or off.
// - Soft clip offset code 00 means level equal to the peak-white limit.
// - Blue stretch cuts red and green gain for input above 80% amplitude.
// - Discharge enable bit selects a fixed beam current during switch-off.
// - Standby: finish field, then slow stop with optional fixed beam.
// - Switch-off parks vertical in overscan if its bit is one, else scans.
// - Standby slow stop lasts 42 ms; fixed beam flows its first 37 ms.
// - Mains loss: finish field, force fixed beam, keep horizontal running.
// - Mains loss: supply under reset level stops horizontal and fixed beam.
// - Grounded line-rate pin gives single rate, open pin gives double rate.
// - Phase loop corrects fraction k of flyback phase error every line.
// - Black current loop is closed only on measurement lines or fixed beam.
// - Supply under reset level sets the reset flag and stops horizontal.
// - Slow stop starts with the first new vertical field after the command.
package tube_seq_pkg;
   // Register byte offsets.
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] PHASE_K_OFS = 8'h08;
   // Control register fields.
   localparam int REL_LSB = 0;
   localparam int FBLANK_BIT = 2;
   localparam int BSTR_BIT = 3;
   localparam int FBEAM_BIT = 4;
   localparam int OSCAN_BIT = 5;
   localparam int SCLIP_LSB = 6;
   localparam int STANDBY_BIT = 8;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // Status register fields.
   localparam int FAULT_BIT = 0;
   localparam int WIN_BIT = 1;
   localparam int ABOVE_BIT = 2;
   localparam int POR_BIT = 3;
   localparam int DRATE_BIT = 4;
   localparam int STATE_LSB = 8;
   // Phase loop factor, a fraction in sixteenths; 8 gives k of one half.
   localparam logic [4:0] PHASE_K_RST = 5'h08;
   localparam int PHASE_K_SHIFT = 4;
   // Soft clip codes; 11 switches the clipper off.
   localparam logic [1:0] SCLIP_OFF = 2'h3;
   // Cutoff levels in millivolts.
   localparam logic [11:0] CUT_LOW_MV = 12'd1500;
   localparam logic [11:0] CUT_HIGH_MV = 12'd3500;
   localparam logic [11:0] CUT_TARGET_MV = 12'd2500;
   localparam logic [11:0] CUT_WINDOW_MV = 12'd100;
   // Video amplitude scale: nominal 1000, blue stretch knee at 80 percent.
   localparam logic [9:0] BSTR_KNEE = 10'd800;
   // Times in their own units and derived clock counts.
   localparam int CLK_KHZ = 40000;
   localparam int BLANK_HOLD_MS = 500;
   localparam int SLOW_STOP_MS = 42;
   localparam int FBEAM_MS = 37;
   localparam int BLANK_HOLD_CYC = BLANK_HOLD_MS * CLK_KHZ;
   localparam int SLOW_STOP_CYC = SLOW_STOP_MS * CLK_KHZ;
   localparam int FBEAM_CYC = FBEAM_MS * CLK_KHZ;
   localparam logic [7:0] ON_TIME_NOM = 8'hff;
   // Sequencer states, one-hot.
   typedef enum logic [5:0] {
      ST_OFF = 6'h01,
      ST_RUN = 6'h02,
      ST_STBY_WAIT = 6'h04,
      ST_SOFT_STOP = 6'h08,
      ST_MAINS_WAIT = 6'h10,
      ST_DISCHARGE = 6'h20
   } seq_state_t;
endpackage

/* tube_seq_tb.sv */
`timescale 1ns/100ps
`define CHK(g, e) cmp(32'(g), 32'(e), `__LINE__)
`define WAITF(c, n) for (i = 0; i < (n) && !(c); i++) @(posedge hclk); \
   if (!(c)) hang();
module tube_seq_tb;
   import tube_seq_pkg::*;
   localparam int HOLD = 50, STOP = 600, BEAM = 500;
   typedef struct {logic [31:0] v; logic [31:0] m;} note_t;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, sag = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata;
   logic [1:0] htrans = 0, soft_clip_offset;
   logic [2:0] hsize = 3'h2;
   logic [11:0] cut_r_mv = 12'd2500, cut_g_mv = 12'd1400;
   logic [11:0] cut_b_mv = 12'd2500;
   logic [9:0] video_level = 10'd801;
   logic signed [11:0] phase_err = 0, phase_corr;
   logic line_rate_sel_pin = 1, rd_pend = 0, hreadyout, field_start;
   logic meas_line, mains_loss_discharge_pin, supply_ok_pin, h_out_en;
   logic rgb_blank, cathode_calibration_loop, loop_closed;
   logic fixed_beam_force, vert_overscan, soft_clip_on, rg_gain_reduce;
   logic double_rate, hresp;
   logic [7:0] h_on_time;
   logic [11:0] lvl[4] = '{12'd2550, 12'd2350, 12'd2450, 12'd2700};
   logic [31:0] wexp[4] = '{32'h6, 32'h0, 32'h2, 32'h4};
   note_t notes[$];
   note_t nt;
   int mismatches = 0, comparisons = 0, i, k, kv, pe;

   always #12.5 hclk = ~hclk;

   tube_seq #(.HOLD_CYC(HOLD), .STOP_CYC(STOP), .BEAM_CYC(BEAM)) dut (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .cut_r_mv,
      .cut_g_mv, .cut_b_mv, .meas_line, .field_start, .video_level,
      .phase_err, .mains_loss_discharge_pin, .line_rate_sel_pin,
      .supply_ok_pin, .h_out_en, .h_on_time, .rgb_blank,
      .cathode_calibration_loop, .loop_closed, .fixed_beam_force,
      .vert_overscan, .soft_clip_offset, .soft_clip_on, .rg_gain_reduce,
      .double_rate, .phase_corr);

   defl_partner #(.FIELD(100), .DROP(400)) far_side (.hclk, .sag,
      .field_start, .meas_line, .mains_loss_discharge_pin, .supply_ok_pin);

   task automatic cmp(input logic [31:0] g, e, input int ln);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %0t line %0d got %h want %h", $time, ln, g, e);
      end
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic hang;
      mismatches++;
      $display("[FAIL] %0t wait ran out", $time);
      tally_and_finish();
   endtask

   // The slave never stretches a phase; ready is still awaited with a bound.
   task automatic rdy;
      int n = 0;
      do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 20);
      if (n >= 20) hang();
   endtask

   // One single word transfer; a read leaves its expectation behind.
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] m = '1);
      @(posedge hclk);
      hsel <= 1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      rdy();
      if (!w)
         notes.push_back('{d, m});
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
   endtask

   // Read data is judged in its data phase against the oldest note.
   always @(posedge hclk) begin
      if (rd_pend && notes.size() > 0) begin
         nt = notes.pop_front();
         `CHK(hrdata & nt.m, nt.v);
         `CHK(hresp, 0);
      end
      rd_pend <= hsel && htrans[1] && !hwrite && hreadyout;
   end

   initial begin
      void'($urandom(27674));
      repeat (3) @(posedge hclk);
      hresetn <= 1;
      repeat (4) @(posedge hclk);
      bus(1, 8'h04, 32'h8);
      bus(0, 8'h04, 32'h0, 32'h8);
      bus(0, 8'h00, 32'h0);
      bus(0, 8'h08, 32'h8);
      bus(0, 8'h0c, 32'h0);
      $display("test reset done");
      // A cold tube keeps the fault set and the picture blanked.
      bus(1, 8'h00, 32'h1);
      `WAITF(h_out_en === 1'b1, 10)
      `CHK(cathode_calibration_loop, 1);
      repeat (HOLD + 20) @(posedge hclk);
      `CHK(rgb_blank, 1);
      bus(0, 8'h04, 32'h1, 32'h1);
      cut_g_mv <= 12'd2900;
      cut_b_mv <= 12'd2800;
      `WAITF(rgb_blank === 1'b0, 6)
      bus(0, 8'h04, 32'h0, 32'h1);
      $display("test warm up done");
      for (k = 0; k < 4; k++) begin
         cut_r_mv <= lvl[k];
         repeat (3) @(posedge hclk);
         bus(0, 8'h04, wexp[k], 32'h7);
      end
      cut_r_mv <= 12'd2500;
      $display("test cutoff window done");
      bus(1, 8'h00, 32'h5);
      repeat (3) @(posedge hclk);
      `CHK(rgb_blank, 1);
      bus(1, 8'h00, 32'h1);
      repeat (3) @(posedge hclk);
      `CHK(rgb_blank, 0);
      $display("test force blank done");
      for (k = 0; k < 4; k++) begin
         bus(1, 8'h00, 32'h1 | (k << 6) | ((k & 1) << 3));
         repeat (3) @(posedge hclk);
         `CHK(soft_clip_offset, k);
         `CHK(soft_clip_on, k != 3);
         `CHK(rg_gain_reduce, k & 1);
      end
      `CHK(double_rate, 1);
      video_level <= 10'd800;
      line_rate_sel_pin <= 0;
      repeat (5) @(posedge hclk);
      `CHK(rg_gain_reduce, 0);
      `CHK(double_rate, 0);
      for (k = 0; k < 100; k++) begin
         @(posedge hclk);
         `CHK(loop_closed, meas_line);
      end
      $display("test settings done");
      for (k = 0; k < 4; k++) begin
         pe = int'($urandom % 128) - 64;
         kv = (k == 0) ? 8 : int'($urandom % 16);
         phase_err <= 12'(pe);
         bus(1, 8'h08, 32'(kv));
         repeat (3) @(posedge hclk);
         `CHK(phase_corr, 12'((pe * kv) >>> 4));
      end
      $display("test phase loop done");
      // Standby with beam discharge and overscan parking.
      bus(1, 8'h00, 32'h131);
      `WAITF(fixed_beam_force === 1'b1, 150)
      repeat (2) @(posedge hclk);
      `CHK(vert_overscan, 1);
      `CHK(h_on_time > 8'he0, 1);
      `WAITF(fixed_beam_force === 1'b0, BEAM + 5)
      `CHK(i >= BEAM - 5, 1);
      `CHK(h_on_time < 8'h60, 1);
      k = i;
      `WAITF(h_out_en === 1'b0, STOP)
      `CHK(k + i >= STOP - 6 && k + i <= STOP + 4, 1);
      `CHK(h_on_time, 0);
      bus(0, 8'h04, 32'h100, 32'h3f00);
      $display("test standby done");
      bus(1, 8'h00, 32'h11);
      `WAITF(h_out_en === 1'b1, 10)
      `WAITF(rgb_blank === 1'b0, HOLD + 10)
      `CHK(i >= HOLD - 3, 1);
      sag <= 1;
      `WAITF(fixed_beam_force === 1'b1, 150)
      repeat (2) @(posedge hclk);
      `CHK(h_out_en, 1);
      `CHK(vert_overscan, 0);
      `WAITF(h_out_en === 1'b0, 600)
      repeat (2) @(posedge hclk);
      `CHK(fixed_beam_force, 0);
      bus(0, 8'h04, 32'h8, 32'h8);
      sag <= 0;
      $display("test mains loss done");
      tally_and_finish();
   end
endmodule // tube_seq_tb
